// file: touch_params.svh
`ifndef TOUCH_PARAMS_SVH
`define TOUCH_PARAMS_SVH


// Control byte field positions.
`define CB_START 7
`define CB_CHAN_HI 6
`define CB_CHAN_LO 4
`define CB_MODE 3
`define CB_REF 2
`define CB_PD_HI 1
`define CB_PD_LO 0

// Serial sequence counts, in serial clock edges.
`define ACQ_AT_BIT 4'd5
`define CTRL_BITS 4'd8
`define BITS_FULL 4'd12
`define BITS_SHORT 4'd8
`define OVERLAP_LEAD 4'd5
`define XFER_EDGES 5'd24
`define RX_MSB 14

// Channel select codes.
`define CH_TEMP_LO 3'h0
`define CH_Y_POS 3'h1
`define CH_BATTERY 3'h2
`define CH_Z_FIRST 3'h3
`define CH_Z_SECOND 3'h4
`define CH_X_POS 3'h5
`define CH_TEMP_HI 3'h7

// Host controller register offsets and reset values.
`define OFF_CMD 8'h00
`define OFF_STATUS 8'h04
`define OFF_RESULT 8'h08
`define OFF_DIV 8'h0c
`define OFF_SETTLE 8'h10
`define DIV_RESET 16'h0001
`define SETTLE_RESET 16'h0000

`endif

// file: touch_pkg.sv
package touch_pkg;

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_CTRL = 2'b01,
        DEV_ACQ = 2'b10
    } dev_state_t;

    typedef enum logic [0:0] {
        HOST_IDLE = 1'b0,
        HOST_RUN = 1'b1
    } host_state_t;

    typedef struct packed {
        dev_state_t st;
        logic prev_clk;
        logic [3:0] bitcnt;
        logic [7:0] ctrl;
        logic [2:0] chan;
        logic eight_bit;
        logic ref_single;
        logic pd_high;
        logic pd_low;
        logic conv_busy;
        logic [3:0] step;
        logic [3:0] conv_len;
        logic [11:0] sample;
        logic [12:0] out_sr;
        logic [3:0] out_left;
        logic dout;
        logic x_drv;
        logic y_drv;
        logic temp_lo;
        logic temp_hi;
        logic bat_div;
        logic hold;
        logic adc_on;
        logic ymin_sw;
        logic [11:0] result;
        logic result_valid;
    } dev_regs_t;

    typedef struct packed {
        host_state_t st;
        logic sclk;
        logic din;
        logic [15:0] half;
        logic [4:0] edges;
        logic [7:0] tx;
        logic [23:0] rx;
        logic [7:0] cmd;
        logic [15:0] div;
        logic [15:0] settle;
        logic [11:0] result;
        logic done;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } host_regs_t;

endpackage : touch_pkg

// file: touch_link_if.sv
`timescale 1ns/1ps

// Three-wire serial link between the host controller and the converter.
interface touch_link_if;
    logic serial_clock_in;
    logic serial_data_in;
    logic serial_data_out;

    modport device (
        input serial_clock_in,
        input serial_data_in,
        output serial_data_out
    );

    modport host (
        output serial_clock_in,
        output serial_data_in,
        input serial_data_out
    );
endinterface : touch_link_if

// file: touch_adc_device.sv
`timescale 1ns/1ps
`include "touch_params.svh"

module touch_adc_device (
    input wire logic ref_clk,
    input wire logic srst,
    touch_link_if.device link,
    input wire logic [11:0] sample_value,
    output logic x_drivers_on,
    output logic y_drivers_on,
    output logic temp_diode_low_current,
    output logic temp_diode_high_current,
    output logic battery_divider_on,
    output logic sample_hold,
    output logic adc_powered,
    output logic yminus_switch_on,
    output logic reference_mode_select,
    output logic [2:0] active_channel,
    output logic [11:0] result_word,
    output logic result_valid
);
    import touch_pkg::*;

    dev_regs_t q;
    dev_regs_t d;
    logic rise;
    logic fall;
    logic [7:0] byte_now;
    logic [3:0] nbits;

    // Panel drivers that a channel needs, as {x, y}.
    function automatic logic [1:0] chan_drivers(input logic [2:0] chan);
        logic [1:0] drv;
        drv = 2'b00;
        case (chan)
            `CH_Y_POS: drv = 2'b01;
            `CH_Z_FIRST: drv = 2'b11;
            `CH_Z_SECOND: drv = 2'b11;
            `CH_X_POS: drv = 2'b10;
            default: drv = 2'b00;
        endcase
        return drv;
    endfunction : chan_drivers

    // Result width chosen by the resolution bit.
    function automatic logic [3:0] res_bits(input logic eight);
        return eight ? `BITS_SHORT : `BITS_FULL;
    endfunction : res_bits

    // Next state. The serial clock is sampled on ref_clk, so it must run
    // at well under half the reference rate for both edges to be seen.
    always_comb
    begin
        d = q;
        d.result_valid = 1'b0;
        d.prev_clk = link.serial_clock_in;
        rise = link.serial_clock_in & ~q.prev_clk;
        fall = ~link.serial_clock_in & q.prev_clk;
        byte_now = {q.ctrl[6:0], link.serial_data_in};
        nbits = res_bits(q.eight_bit);

        // Data out changes on falling edges so the host samples it stably.
        if (fall)
        begin
            if (q.out_left != 4'h0)
            begin
                d.dout = q.out_sr[12];
                d.out_sr = {q.out_sr[11:0], 1'b0};
                d.out_left = q.out_left - 4'h1;
            end
            else
            begin
                d.dout = 1'b0;
            end
        end

        // Conversion steps; the step counter ignores trailing clocks.
        if (rise && q.conv_busy)
        begin
            d.step = q.step + 4'h1;
            if (q.step + 4'h1 == q.conv_len)
            begin
                d.conv_busy = 1'b0;
                d.result = q.eight_bit ? {4'h0, q.sample[11:4]} : q.sample;
                d.result_valid = 1'b1;
                // A byte already under way owns the panel, so leave it alone.
                if (q.st == DEV_IDLE)
                begin
                    d.hold = 1'b0;
                    if (!q.pd_low)
                    begin
                        d.x_drv = 1'b0;
                        d.y_drv = 1'b0;
                        d.adc_on = 1'b0;
                        d.ymin_sw = 1'b1;
                    end
                    else
                    begin
                        d.adc_on = 1'b1;
                    end
                end
            end
        end

        // Control byte reception and sequencing.
        if (rise)
        begin
            case (q.st)
                DEV_IDLE:
                begin
                    // A start bit is only honoured once the running
                    // conversion is close enough to its end to overlap.
                    // The sum is one bit wider so late steps cannot wrap.
                    if (link.serial_data_in &&
                        (!q.conv_busy ||
                         ({1'b0, q.step} + {1'b0, `OVERLAP_LEAD} >= {1'b0, nbits})))
                    begin
                        d.st = DEV_CTRL;
                        d.bitcnt = 4'h1;
                        d.ctrl = 8'h01;
                    end
                end
                DEV_CTRL:
                begin
                    d.ctrl = byte_now;
                    d.bitcnt = q.bitcnt + 4'h1;
                    if (q.bitcnt + 4'h1 == `ACQ_AT_BIT)
                    begin
                        // Channel bits now sit in bits 3..1 of the shifter.
                        d.st = DEV_ACQ;
                        d.chan = byte_now[3:1];
                        {d.x_drv, d.y_drv} = chan_drivers(byte_now[3:1]);
                        d.temp_lo = (byte_now[3:1] == `CH_TEMP_LO);
                        d.temp_hi = (byte_now[3:1] == `CH_TEMP_HI);
                        d.bat_div = (byte_now[3:1] == `CH_BATTERY);
                        d.hold = 1'b0;
                        d.adc_on = 1'b1;
                        d.ymin_sw = 1'b0;
                    end
                end
                DEV_ACQ:
                begin
                    d.ctrl = byte_now;
                    d.bitcnt = q.bitcnt + 4'h1;
                    if (q.bitcnt + 4'h1 == `CTRL_BITS)
                    begin
                        d.st = DEV_IDLE;
                        d.eight_bit = byte_now[`CB_MODE];
                        d.ref_single = byte_now[`CB_REF];
                        d.pd_high = byte_now[`CB_PD_HI];
                        d.pd_low = byte_now[`CB_PD_LO];
                        d.hold = 1'b1;
                        d.temp_lo = 1'b0;
                        d.temp_hi = 1'b0;
                        d.bat_div = 1'b0;
                        d.sample = sample_value;
                        if (byte_now[`CB_REF])
                        begin
                            d.x_drv = 1'b0;
                            d.y_drv = 1'b0;
                        end
                        // Ratiometric needs one more clock for the last bit.
                        d.conv_len = res_bits(byte_now[`CB_MODE]) +
                            {3'h0, ~byte_now[`CB_REF]};
                        d.conv_busy = 1'b1;
                        d.step = 4'h0;
                        // Leading zero fills the first conversion clock.
                        d.out_sr = {1'b0, sample_value};
                        d.out_left = res_bits(byte_now[`CB_MODE]) + 4'h1;
                    end
                end
                default:
                begin
                    d.st = DEV_IDLE;
                end
            endcase
        end
    end

    // State register; after reset the part sits powered down, Y-minus on.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            q <= '0;
            q.st <= DEV_IDLE;
            q.ymin_sw <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // Every output is a field of the state register.
    assign link.serial_data_out = q.dout;
    assign x_drivers_on = q.x_drv;
    assign y_drivers_on = q.y_drv;
    assign temp_diode_low_current = q.temp_lo;
    assign temp_diode_high_current = q.temp_hi;
    assign battery_divider_on = q.bat_div;
    assign sample_hold = q.hold;
    assign adc_powered = q.adc_on;
    assign yminus_switch_on = q.ymin_sw;
    assign reference_mode_select = q.ref_single;
    assign active_channel = q.chan;
    assign result_word = q.result;
    assign result_valid = q.result_valid;

endmodule : touch_adc_device

// file: touch_host_ctrl.sv
`timescale 1ns/1ps
`include "touch_params.svh"

module touch_host_ctrl (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    touch_link_if.host link
);
    import touch_pkg::*;

    host_regs_t q;
    host_regs_t d;
    logic access;

    always_comb
    begin
        d = q;
        access = psel & penable & ~q.pready;
        d.pready = access;
        d.pslverr = 1'b0;

        // Register access; answered one cycle into the access phase.
        if (access)
        begin
            case (paddr)
                `OFF_CMD:
                begin
                    d.prdata = {24'h0, q.cmd};
                    // A command written while a transfer runs is dropped.
                    if (pwrite && q.st == HOST_IDLE)
                    begin
                        d.cmd = pwdata[7:0];
                        d.st = HOST_RUN;
                        d.sclk = 1'b0;
                        d.din = pwdata[7];
                        d.tx = {pwdata[6:0], 1'b0};
                        d.edges = 5'h0;
                        d.half = q.div;
                        d.done = 1'b0;
                    end
                end
                `OFF_STATUS:
                begin
                    d.prdata = {30'h0, q.done, q.st == HOST_RUN};
                    if (pwrite && pwdata[1])
                    begin
                        d.done = 1'b0;
                    end
                end
                `OFF_RESULT: d.prdata = {20'h0, q.result};
                `OFF_DIV:
                begin
                    d.prdata = {16'h0, q.div};
                    if (pwrite)
                    begin
                        d.div = pwdata[15:0];
                    end
                end
                `OFF_SETTLE:
                begin
                    d.prdata = {16'h0, q.settle};
                    if (pwrite)
                    begin
                        d.settle = pwdata[15:0];
                    end
                end
                default:
                begin
                    d.prdata = 32'h0;
                    d.pslverr = 1'b1;
                end
            endcase
        end

        // Serial clock generation; the done flag is set here, after any
        // software clear above, so a finishing transfer is never lost.
        if (q.st == HOST_RUN)
        begin
            if (q.half != 16'h0)
            begin
                d.half = q.half - 16'h1;
            end
            else if (!q.sclk)
            begin
                d.sclk = 1'b1;
                d.edges = q.edges + 5'h1;
                d.rx = {q.rx[22:0], link.serial_data_out};
                d.half = q.div;
            end
            else
            begin
                d.sclk = 1'b0;
                if (q.edges == `XFER_EDGES)
                begin
                    d.st = HOST_IDLE;
                    d.done = 1'b1;
                    d.din = 1'b0;
                    d.result = q.cmd[`CB_MODE] ?
                        {4'h0, q.rx[`RX_MSB -: 8]} : q.rx[`RX_MSB -: 12];
                end
                else
                begin
                    d.din = q.tx[7];
                    d.tx = {q.tx[6:0], 1'b0};
                    // Stretch the low phase inside acquisition for settling.
                    d.half = (q.edges == {1'b0, `ACQ_AT_BIT}) ?
                        16'(q.div + q.settle) : q.div;
                end
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            q <= '0;
            q.st <= HOST_IDLE;
            q.div <= `DIV_RESET;
            q.settle <= `SETTLE_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign link.serial_clock_in = q.sclk;
    assign link.serial_data_in = q.din;

endmodule : touch_host_ctrl

// file: touch_adc_serial_sequencer_properties.sv
`timescale 1ns/1ps

// Watches the serial link and the converter outputs; the result deadline is in reference clocks, the bias window in serial rises.
module touch_adc_serial_sequencer_properties (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic serial_clock_in,
    input wire logic serial_data_out,
    input wire logic x_drivers_on,
    input wire logic y_drivers_on,
    input wire logic temp_diode_low_current,
    input wire logic temp_diode_high_current,
    input wire logic battery_divider_on,
    input wire logic sample_hold,
    input wire logic adc_powered,
    input wire logic yminus_switch_on,
    input wire logic reference_mode_select,
    input wire logic [2:0] active_channel,
    input wire logic result_valid
);
    logic sclk_q;
    logic [3:0] bias_rises_q;

    // Counts serial rises while any bias network is on, since bias must cover acquisition only.
    always_ff @(posedge ref_clk)
    begin
        sclk_q <= serial_clock_in;
        if (srst || !(temp_diode_low_current || temp_diode_high_current || battery_divider_on))
            bias_rises_q <= 4'h0;
        else if (serial_clock_in && !sclk_q)
            bias_rises_q <= bias_rises_q + 4'h1;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // Hold marks the end of acquisition; the result must follow within one serial frame.
    sequence s_hold_start;
        $rose(sample_hold);
    endsequence
    sequence s_result_due;
        ##[1:150] result_valid;
    endsequence

    property p_temp_lo;
        temp_diode_low_current |-> active_channel == 3'h0;
    endproperty
    a_temp_lo: assert property (p_temp_lo) else $error("low bias on wrong channel");
    property p_temp_hi;
        temp_diode_high_current |-> active_channel == 3'h7;
    endproperty
    a_temp_hi: assert property (p_temp_hi) else $error("high bias on wrong channel");
    property p_bias_window;
        bias_rises_q <= 4'h3;
    endproperty
    a_bias_window: assert property (p_bias_window) else $error("bias on too long");
    property p_battery;
        battery_divider_on |-> active_channel == 3'h2;
    endproperty
    a_battery: assert property (p_battery) else $error("divider on wrong channel");
    property p_drivers;
        (x_drivers_on |-> active_channel inside {3'h3, 3'h4, 3'h5})
            and (y_drivers_on |-> active_channel inside {3'h1, 3'h3, 3'h4});
    endproperty
    a_drivers: assert property (p_drivers) else $error("drivers on wrong channel");
    property p_single_drop;
        s_hold_start ##0 reference_mode_select |-> !x_drivers_on && !y_drivers_on;
    endproperty
    a_single_drop: assert property (p_single_drop) else $error("drivers kept in hold");
    property p_ratio_keep;
        s_hold_start ##0 (!reference_mode_select && active_channel == 3'h1) |-> y_drivers_on;
    endproperty
    a_ratio_keep: assert property (p_ratio_keep) else $error("drivers lost in hold");
    property p_conv_done;
        s_hold_start |-> s_result_due;
    endproperty
    a_conv_done: assert property (p_conv_done) else $error("no result after hold");
    property p_power_up;
        s_hold_start |-> adc_powered;
    endproperty
    a_power_up: assert property (p_power_up) else $error("converter unpowered");
    property p_sleep;
        result_valid && !adc_powered |-> yminus_switch_on && !x_drivers_on && !y_drivers_on;
    endproperty
    a_sleep: assert property (p_sleep) else $error("bad power-down state");
    property p_dout_edge;
        $changed(serial_data_out) |-> !serial_clock_in;
    endproperty
    a_dout_edge: assert property (p_dout_edge) else $error("data out moved in high phase");
endmodule : touch_adc_serial_sequencer_properties

// file: test_touch_adc_serial_sequencer.sv
`timescale 1ns/1ps
`include "touch_params.svh"

// Drives the host controller over APB and checks both ends of the serial link.
module test_touch_adc_serial_sequencer;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [11:0] sample_value = 12'h000;
    logic [31:0] prdata;
    logic pready, pslverr, x_drivers_on, y_drivers_on, temp_diode_low_current;
    logic temp_diode_high_current, battery_divider_on, sample_hold, adc_powered;
    logic yminus_switch_on, reference_mode_select, result_valid;
    logic [2:0] active_channel;
    logic [11:0] result_word;
    int num_errors = 0;
    int cmp_count = 0;
    int rises = 0;
    logic sclk_seen = 1'b0;
    logic seen_lo = 1'b0;
    logic seen_hi = 1'b0;
    logic seen_bat = 1'b0;
    logic [7:0] din_sr;
    logic [23:0] dout_sr;
    logic [14:0] exp_q[$];
    logic [14:0] head;
    logic [31:0] rd;
    logic e;

    always #20 ref_clk = ~ref_clk;

    touch_link_if link_if();
    touch_adc_device u_touch_adc_device (.ref_clk, .srst, .link(link_if), .sample_value,
        .x_drivers_on, .y_drivers_on, .temp_diode_low_current, .temp_diode_high_current,
        .battery_divider_on, .sample_hold, .adc_powered, .yminus_switch_on,
        .reference_mode_select, .active_channel, .result_word, .result_valid);
    touch_host_ctrl u_touch_host_ctrl (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .link(link_if));
    touch_adc_serial_sequencer_properties props (.ref_clk, .srst,
        .serial_clock_in(link_if.serial_clock_in), .serial_data_out(link_if.serial_data_out),
        .x_drivers_on, .y_drivers_on, .temp_diode_low_current, .temp_diode_high_current,
        .battery_divider_on, .sample_hold, .adc_powered, .yminus_switch_on,
        .reference_mode_select, .active_channel, .result_valid);

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic give_up(input string name);
        num_errors++;
        $display("Error %s expected completion seen none", name);
        print_verdict();
    endtask : give_up

    // Samples the link at mid-cycle so the flops of both ends have settled.
    always @(negedge ref_clk)
    begin
        if (link_if.serial_clock_in === 1'b1 && sclk_seen === 1'b0)
        begin
            rises++;
            if (rises <= 8)
                din_sr = {din_sr[6:0], link_if.serial_data_in};
            dout_sr = {dout_sr[22:0], link_if.serial_data_out};
        end
        sclk_seen = link_if.serial_clock_in;
        seen_lo = seen_lo | (temp_diode_low_current === 1'b1);
        seen_hi = seen_hi | (temp_diode_high_current === 1'b1);
        seen_bat = seen_bat | (battery_divider_on === 1'b1);
    end

    // Each result pulse consumes the oldest expectation noted by the driver.
    always @(negedge ref_clk)
        if (result_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("spare result", 32'h0, 32'h1);
            else
            begin
                head = exp_q.pop_front();
                chk("result_word", 32'(head[11:0]), 32'(result_word));
                chk("active_channel", 32'(head[14:12]), 32'(active_channel));
            end
        end

    // One APB transfer; the request stands until pready is seen at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rdata, output logic err);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        // Ready is judged only at rising edges, with the request still standing.
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 50)
            give_up("pready");
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Runs one 24-clock conversion and checks the wire and the outcome.
    task automatic convert(input logic [2:0] ch, input logic m, input logic r,
        input logic [1:0] pd, input logic [15:0] settle, input logic dup);
        logic [7:0] cb;
        logic [11:0] s;
        logic [11:0] x;
        logic [23:0] wire_exp;
        logic [1:0] drv;
        int n;
        cb = {1'b1, ch, m, r, pd};
        s = 12'($urandom);
        x = m ? {4'h0, s[11:4]} : s;
        wire_exp = m ? {9'h0, s[11:4], 7'h0} : {9'h0, s, 3'h0};
        drv = {ch inside {3'h3, 3'h4, 3'h5}, ch inside {3'h1, 3'h3, 3'h4}};
        sample_value <= s;
        apb(1'b1, `OFF_SETTLE, 32'(settle), rd, e);
        exp_q.push_back({ch, x});
        rises = 0;
        seen_lo = 1'b0;
        seen_hi = 1'b0;
        seen_bat = 1'b0;
        apb(1'b1, `OFF_CMD, 32'(cb), rd, e);
        // A second order while busy must be dropped without trace.
        if (dup)
            apb(1'b1, `OFF_CMD, 32'h0000_00f0, rd, e);
        n = 0;
        rd = 32'h0;
        while (rd[1] !== 1'b1 && n < 400)
        begin
            apb(1'b0, `OFF_STATUS, 32'h0, rd, e);
            n++;
        end
        if (n >= 400)
            give_up("status done");
        apb(1'b0, `OFF_RESULT, 32'h0, rd, e);
        chk("result reg", 32'(x), rd);
        chk("serial rises", 32'd24, 32'(rises));
        chk("control byte", 32'(cb), 32'(din_sr));
        chk("data out", 32'(wire_exp), 32'(dout_sr));
        chk("drivers after", 32'((pd[0] && !r) ? drv : 2'b00), 32'({x_drivers_on, y_drivers_on}));
        chk("low bias seen", 32'(ch == 3'h0), 32'(seen_lo));
        chk("high bias seen", 32'(ch == 3'h7), 32'(seen_hi));
        chk("divider seen", 32'(ch == 3'h2), 32'(seen_bat));
        chk("reference mode", 32'(r), 32'(reference_mode_select));
        chk("converter power", 32'(pd[0]), 32'(adc_powered));
        if (pd == 2'b00)
            chk("yminus", 32'h1, 32'(yminus_switch_on));
    endtask : convert

    initial
    begin
        void'($urandom(28));
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        apb(1'b0, `OFF_DIV, 32'h0, rd, e);
        chk("div reset", 32'(`DIV_RESET), rd);
        apb(1'b0, `OFF_SETTLE, 32'h0, rd, e);
        chk("settle reset", 32'(`SETTLE_RESET), rd);
        apb(1'b0, 8'h20, 32'h0, rd, e);
        chk("unmapped error", 32'h1, 32'(e));
        // Three reference clocks a phase leave the device room to see every serial edge.
        apb(1'b1, `OFF_DIV, 32'h2, rd, e);
        $display("test registers done");
        // Every channel code, both resolutions and both reference modes.
        for (int c = 0; c < 8; c++)
            convert(3'(c), c[0], !(c == 1 || c == 4), 2'b00, 16'h0, 1'b0);
        $display("test channels done");
        convert(3'h5, 1'b0, 1'b0, 2'b01, 16'h0, 1'b0);
        convert(3'h5, 1'b0, 1'b0, 2'b01, 16'd40, 1'b0);
        convert(3'h5, 1'b1, 1'b0, 2'b00, 16'h0, 1'b0);
        // Pressure readings at the coarse resolution, ratiometric.
        convert(3'h4, 1'b1, 1'b0, 2'b00, 16'h0, 1'b0);
        $display("test series done");
        convert(3'h2, 1'b0, 1'b1, 2'b00, 16'h0, 1'b1);
        apb(1'b1, `OFF_STATUS, 32'h2, rd, e);
        apb(1'b0, `OFF_STATUS, 32'h0, rd, e);
        chk("done cleared", 32'h0, 32'(rd[1]));
        repeat (4) @(posedge ref_clk);
        chk("pending results", 32'h0, 32'(exp_q.size()));
        $display("test busy done");
        print_verdict();
    end
endmodule : test_touch_adc_serial_sequencer
